// ==== hw/async_char_serializer.sv ====
// Asynchronous character serializer: parallel load, start bit, data, stop.
// Assumes rate_clk runs at twice the bit rate and all inputs are synchronous to clk.
`include "char_tx_defines.svh"

//Contract
// - Strap selects 5-bit or 8-bit characters
// - Frame is 7-8 or 10-11 units
// - Start bit, data bit 1 first, stop
// - Stop length strap 1.0, 1.5, 2.0
// - Done flag drops at stop start
// - Strobes act only when selected or bypassed
// - Query output low pulse when flag clear
// - Selected high clear input clears flag
// - Low direct clear input clears flag when bypass is low
// - Hold-off low delays next character start
// - Initialize clears shifter and control state
// - High data input sends as mark
// - Channel enable low suppresses loaded character in 8-bit mode
// - Active high from start to stop
module async_char_serializer #(
   parameter int DATA_W = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rate_clk,
   input wire logic long_char,
   input wire char_tx_pkg::stop_len_t stop_len,
   input wire logic [5:0] device_code_bits,
   input wire logic select_bypass_n,
   input wire logic query_strobe,
   input wire logic load_strobe,
   input wire logic clear_selected,
   input wire logic clear_direct_n,
   input wire logic hold_off_n,
   input wire logic init,
   input wire logic [DATA_W-1:0] char_data,
   input wire logic channel_enable,
   output logic load_ready,
   output logic serial_out,
   output logic active,
   output logic done_flag,
   output logic query_result_n
);
   import char_tx_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   tx_state_t state;
   logic tick;
   logic selected;
   logic load_take;
   logic fifo_valid;
   logic fifo_ready;
   logic fifo_in_ready;
   logic [DATA_W-1:0] fifo_data;
   logic [DATA_W-1:0] shifter;
   logic [3:0] bit_left;
   logic [2:0] half_cnt;
   logic [2:0] stop_halves;
   logic enable_level;
   logic hold_latched;
   logic flag;
   logic line_bit;

   function automatic logic [2:0] stop_half_count(input stop_len_t len);
      unique case (len)
         STOP_1_0: stop_half_count = 3'(`STOP_HALVES_1_0);
         STOP_1_5: stop_half_count = 3'(`STOP_HALVES_1_5);
         STOP_2_0: stop_half_count = 3'(`STOP_HALVES_2_0);
         default: stop_half_count = 3'(`STOP_HALVES_2_0);
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Device selection and strobes
   // ----------------------------------------------------------------
   assign selected = !select_bypass_n || (&device_code_bits);
   // In 5-bit mode data input 6 is the enable level
   assign enable_level = long_char ? channel_enable : char_data[5];
   assign load_take = load_strobe && selected && enable_level && fifo_in_ready;

   half_bit_tick u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .rate_clk(rate_clk),
      .tick(tick)
   );

   char_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .flush(init),
      .in_valid(load_take),
      .in_ready(fifo_in_ready),
      .in_data(char_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   assign stop_halves = stop_half_count(stop_len);
   // Next frame starts on a half-bit tick when not held off
   assign fifo_ready = (state == TX_IDLE) && tick && hold_off_n && !init;

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= TX_IDLE;
         shifter <= '0;
         bit_left <= '0;
         half_cnt <= '0;
         line_bit <= 1'b1;
      end
      else if (init)
      begin
         state <= TX_IDLE;
         shifter <= '0;
         bit_left <= '0;
         half_cnt <= '0;
         line_bit <= 1'b1;
      end
      else if (tick)
      begin
         unique case (state)
            TX_IDLE:
            begin
               if (fifo_valid && hold_off_n)
               begin
                  shifter <= fifo_data;
                  line_bit <= 1'b0;
                  bit_left <= long_char ? 4'(`LONG_DATA_BITS) : 4'(`SHORT_DATA_BITS);
                  half_cnt <= 3'(`HALF_UNITS_PER_BIT - 1);
                  state <= TX_DATA;
               end
            end
            TX_DATA:
            begin
               if (half_cnt != '0)
               begin
                  half_cnt <= half_cnt - 1'b1;
               end
               else if (bit_left != '0)
               begin
                  line_bit <= shifter[0];
                  shifter <= {1'b0, shifter[DATA_W-1:1]};
                  bit_left <= bit_left - 1'b1;
                  half_cnt <= 3'(`HALF_UNITS_PER_BIT - 1);
               end
               else
               begin
                  line_bit <= 1'b1;
                  // Leaving stop and idle take one tick each before the next start, so count two fewer
                  half_cnt <= stop_halves - 3'd2;
                  state <= TX_STOP;
               end
            end
            TX_STOP:
            begin
               if (half_cnt != '0)
               begin
                  half_cnt <= half_cnt - 1'b1;
               end
               else
               begin
                  state <= hold_latched ? TX_HOLD : TX_IDLE;
               end
            end
            TX_HOLD:
            begin
               if (hold_off_n)
               begin
                  state <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // Hold-off seen before the stop period blocks the next character
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_latched <= 1'b0;
      end
      else if (init || state == TX_IDLE)
      begin
         hold_latched <= 1'b0;
      end
      else if (state == TX_DATA && !hold_off_n)
      begin
         hold_latched <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Done flag: high means a character is pending or in flight
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag <= 1'b0;
      end
      else if (init)
      begin
         flag <= 1'b0;
      end
      else if (load_take)
      begin
         flag <= 1'b1;
      end
      else if (tick && state == TX_DATA && half_cnt == '0 && bit_left == '0)
      begin
         flag <= 1'b0;
      end
      else if (clear_selected && (&device_code_bits))
      begin
         flag <= 1'b0;
      end
      else if (!clear_direct_n && !select_bypass_n)
      begin
         flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_out <= 1'b1;
         active <= 1'b0;
         done_flag <= 1'b0;
         query_result_n <= 1'b1;
         load_ready <= 1'b0;
      end
      else
      begin
         serial_out <= line_bit;
         active <= (state == TX_DATA);
         done_flag <= flag;
         // NAND of inverted done flag and gated strobe
         query_result_n <= !(query_strobe && selected && !flag);
         load_ready <= fifo_in_ready && !init;
      end
   end
endmodule

// ==== hw/char_fifo.sv ====
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else if (flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== hw/char_tx_defines.svh ====
// Timing and framing constants for the asynchronous character serializer.
// Assumes a single 20 MHz system clock.
`ifndef CHAR_TX_DEFINES_SVH
`define CHAR_TX_DEFINES_SVH

`define CLK_PERIOD_NS 50
`define SETUP_TIME_NS 50
`define SETUP_CYCLES ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_DATA_BITS 5
`define LONG_DATA_BITS 8
`define HALF_UNITS_PER_BIT 2
`define STOP_HALVES_1_0 2
`define STOP_HALVES_1_5 3
`define STOP_HALVES_2_0 4
`define FIFO_DEPTH 16
`define FIFO_WIDTH 8

`endif

// ==== hw/char_tx_pkg.sv ====
// Types shared by the character serializer files.
// Assumes char_tx_defines.svh holds the numeric constants.
package char_tx_pkg;
   typedef enum logic [1:0] {STOP_1_0, STOP_1_5, STOP_2_0} stop_len_t;
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP, TX_HOLD} tx_state_t;
endpackage

// ==== hw/half_bit_tick.sv ====
// Detects rising edges of the external half-bit clock.
// Assumes the rate clock input is already synchronous to clk.
module half_bit_tick (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rate_clk,
   output logic tick
);
   logic rate_prev;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rate_prev <= 1'b0;
      end
      else
      begin
         rate_prev <= rate_clk;
      end
   end

   // Pulse or square wave: one tick per rising edge
   assign tick = rate_clk && !rate_prev;
endmodule

// ==== test/async_char_serializer_chk.sv ====
// Port assertions for the character serializer.
// Assumes rate_clk is synchronous to clk.
module async_char_serializer_chk #(
   parameter int DATA_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rate_clk,
   input wire logic long_char,
   input wire logic [5:0] device_code_bits,
   input wire logic select_bypass_n,
   input wire logic query_strobe,
   input wire logic load_strobe,
   input wire logic clear_selected,
   input wire logic clear_direct_n,
   input wire logic hold_off_n,
   input wire logic init,
   input wire logic [DATA_W-1:0] char_data,
   input wire logic channel_enable,
   input wire logic load_ready,
   input wire logic serial_out,
   input wire logic active,
   input wire logic done_flag,
   input wire logic query_result_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rc_q;
   logic [4:0] ticks;
   wire logic sel = ~select_bypass_n | (&device_code_bits);
   wire logic en = long_char ? channel_enable : char_data[5];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Half-bit ticks seen since the frame went active
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rc_q <= 1'b0;
         ticks <= 5'h00;
      end
      else
      begin
         rc_q <= rate_clk;
         ticks <= $rose(active) ? 5'h00 : ticks + {4'h0, rate_clk & ~rc_q};
      end
   end
   sequence s_query; query_strobe && sel ##1 !done_flag; endsequence
   sequence s_init2; init ##1 init; endsequence
   sequence s_held3; !hold_off_n [*3]; endsequence
   property p_idle; !active |-> serial_out; endproperty
   a_idle: assert property (p_idle) else $error("line low outside frame");
   property p_start; $rose(active) |-> !serial_out; endproperty
   a_start: assert property (p_start) else $error("no start space");
   property p_len; $fell(active) && !init |-> ticks == (long_char ? 5'h12 : 5'h0C); endproperty
   a_len: assert property (p_len) else $error("frame length");
   property p_stop_flag; $fell(active) && !init && !$past(load_strobe) && !load_strobe |=> !done_flag; endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("flag kept at stop");
   property p_query; s_query |-> !query_result_n; endproperty
   a_query: assert property (p_query) else $error("no query pulse");
   property p_load; load_strobe && sel && en && load_ready && !init |=> ##1 done_flag; endproperty
   a_load: assert property (p_load) else $error("load lost");
   property p_clr_sel; clear_selected && &device_code_bits && !load_strobe |=> ##1 !done_flag; endproperty
   a_clr_sel: assert property (p_clr_sel) else $error("selected clear");
   property p_clr_dir; !clear_direct_n && !select_bypass_n && !load_strobe |=> ##1 !done_flag; endproperty
   a_clr_dir: assert property (p_clr_dir) else $error("direct clear");
   property p_init; s_init2 |=> !done_flag && !active && serial_out; endproperty
   a_init: assert property (p_init) else $error("init");
   property p_hold; s_held3 |-> !$rose(active); endproperty
   a_hold: assert property (p_hold) else $error("start under hold");
endmodule

bind async_char_serializer async_char_serializer_chk #(.DATA_W(DATA_W)) chk_u (.clk, .rst_n, .rate_clk,
   .long_char, .device_code_bits, .select_bypass_n, .query_strobe, .load_strobe, .clear_selected,
   .clear_direct_n, .hold_off_n, .init, .char_data, .channel_enable, .load_ready, .serial_out, .active,
   .done_flag, .query_result_n);

// ==== test/async_char_serializer_test.sv ====
// Bench: framing straps, selection, query, clears, hold, FIFO fill, init.
// Assumes design, checker and receiver model compile first.
module async_char_serializer_test;
   timeunit 1ns;
   timeprecision 1ns;
   import char_tx_pkg::*;
   logic clk, rst_n, rate_clk, long_char, select_bypass_n, query_strobe, load_strobe, clear_selected;
   logic clear_direct_n, hold, init, channel_enable, discard, load_ready, serial_out, active;
   logic done_flag, query_result_n, busy_n, got;
   logic [5:0] device_code_bits;
   logic [7:0] char_data;
   logic [8:0] word;
   logic [8:0] q[$];
   stop_len_t stop_len;
   int fails = 0;
   int n_checks = 0;
   integer seed = 32'hdd58d63f;
   int k;
   async_char_serializer dut_u (.clk, .rst_n, .rate_clk, .long_char, .stop_len, .device_code_bits,
      .select_bypass_n, .query_strobe, .load_strobe, .clear_selected, .clear_direct_n,
      .hold_off_n(busy_n & hold), .init, .char_data, .channel_enable, .load_ready, .serial_out, .active,
      .done_flag, .query_result_n);
   serial_rx_model rx_u (.clk, .line_in(serial_out), .long_char, .busy_n, .got, .word);
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      rate_clk = 1'b0;
      forever
      begin
         repeat (2) @(posedge clk);
         #5 rate_clk = ~rate_clk;
      end
   end
   initial
   begin
      #1000000;
      fails++;
      conclude;
   end
   always @(posedge clk)
      if (got === 1'b1 && discard === 1'b0)
         check("rx", word, q.pop_front());
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [7:0] rc();
      logic [7:0] r;
      r = $random(seed);
      return long_char ? r : {3'b001, r[4:0]};
   endfunction
   task load(input logic [7:0] d, input bit take);
      char_data = d;
      cyc(1);
      load_strobe = 1'b1;
      cyc(1);
      load_strobe = 1'b0;
      cyc(2);
      if (take)
         q.push_back(long_char ? {1'b1, d} : {1'b1, 3'b000, d[4:0]});
   endtask
   task automatic drain(input string nm);
      int i;
      for (i = 0; i < 3000 && q.size() != 0; i++)
         cyc(1);
      cyc(20);
      check("drained", q.size() == 0, 1'b1);
      $display("test %s done", nm);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      {rst_n, query_strobe, load_strobe, clear_selected, init, discard, char_data} = '0;
      {clear_direct_n, hold, select_bypass_n, long_char, channel_enable, device_code_bits} = '1;
      stop_len = STOP_1_0;
      cyc(4);
      rst_n = 1'b1;
      for (k = 0; k < 6; k++)
      begin
         long_char = k[0];
         channel_enable = k[0];
         stop_len = stop_len_t'(k / 2);
         repeat (3) load(rc(), 1'b1);
         drain("framing");
      end
      device_code_bits = 6'h3F ^ (6'h01 << ({$random(seed)} % 6));
      load(rc(), 1'b0);
      device_code_bits = 6'h3F;
      channel_enable = 1'b0;
      load(rc(), 1'b0);
      check("flag", done_flag, 1'b0);
      {channel_enable, select_bypass_n, device_code_bits} = 8'h80;
      load(rc(), 1'b1);
      {select_bypass_n, device_code_bits} = '1;
      drain("select");
      query_strobe = 1'b1;
      cyc(1);
      check("query", query_result_n, 1'b0);
      query_strobe = 1'b0;
      cyc(1);
      check("query", query_result_n, 1'b1);
      hold = 1'b0;
      load(8'hA5, 1'b1);
      check("flag", done_flag, 1'b1);
      query_strobe = 1'b1;
      cyc(1);
      check("query", query_result_n, 1'b1);
      query_strobe = 1'b0;
      clear_selected = 1'b1;
      cyc(1);
      clear_selected = 1'b0;
      cyc(1);
      check("flag", done_flag, 1'b0);
      load(8'h3C, 1'b1);
      {select_bypass_n, clear_direct_n} = 2'b00;
      cyc(1);
      {select_bypass_n, clear_direct_n} = 2'b11;
      cyc(1);
      check("flag", done_flag, 1'b0);
      char_data = 8'h5A;
      load_strobe = 1'b1;
      for (k = 0; k < 16; k++)
      begin
         if (k < 14)
            q.push_back(9'h15A);
         cyc(1);
      end
      load_strobe = 1'b0;
      cyc(2);
      check("ready", load_ready, 1'b0);
      check("active", active, 1'b0);
      hold = 1'b1;
      drain("hold_fill");
      check("ready", load_ready, 1'b1);
      discard = 1'b1;
      load(rc(), 1'b0);
      cyc(30);
      init = 1'b1;
      cyc(3);
      init = 1'b0;
      cyc(1);
      check("flag", done_flag, 1'b0);
      check("line", serial_out, 1'b1);
      cyc(200);
      discard = 1'b0;
      load(rc(), 1'b1);
      drain("init");
      conclude;
   end
endmodule

// ==== test/serial_rx_model.sv ====
// Serial receiver on the far side of the line.
// Assumes one bit unit is eight clk cycles.
module serial_rx_model (
   input wire logic clk,
   input wire logic line_in,
   input wire logic long_char,
   output logic busy_n,
   output logic got,
   output logic [8:0] word
);
   timeunit 1ns;
   timeprecision 1ns;
   int i;
   initial
   begin
      {busy_n, got, word} = 11'h400;
      forever
      begin
         @(posedge clk);
         #5;
         got = 1'b0;
         if (line_in === 1'b0)
         begin
            busy_n = 1'b0;
            word = 9'h000;
            repeat (4) @(posedge clk);
            // Samples mid-bit, then the stop level into bit 8
            for (i = 0; i < (long_char ? 8 : 5); i++)
            begin
               repeat (8) @(posedge clk);
               #5 word[i] = line_in;
            end
            repeat (8) @(posedge clk);
            #5 word[8] = line_in;
            busy_n = 1'b1;
            got = 1'b1;
         end
      end
   end
endmodule
